// ### hw/iso_i2c_pkg.sv
// shared constants, types and address decode for the isolated serial slave port
package iso_i2c_pkg;
  // fixed upper address bits and the two special 7-bit addresses
  localparam logic [2:0] ADDR_MSB       = 3'h1;
  localparam logic [6:0] MASS_WR_ADDR   = 7'h1F;
  localparam logic [6:0] ALERT_RSP_ADDR = 7'h0C;
  // three-state strap codes as sensed on an address pin
  localparam logic [1:0] PIN_L  = 2'h0;
  localparam logic [1:0] PIN_H  = 2'h1;
  localparam logic [1:0] PIN_NC = 2'h2;
  // register pointer width and line synchroniser reset value
  localparam int         PTR_W     = 4;
  localparam logic [7:0] SYNC_INIT = 8'h07;
  // cycles that bridge ownership stays locked after a release
  localparam logic [2:0] HOLDOFF = 3'h5;
  // stuck-bus time and its cycle count at the system clock rate
  localparam int CLK_HZ       = 50_000_000;
  localparam int STUCK_MS     = 66;
  localparam int STUCK_CYCLES = STUCK_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE} slave_state_t;
  typedef enum logic [1:0] {OWN_NONE, OWN_LOGIC, OWN_ISO} data_owner_t;

  // strap pair to {broadcast, address index}
  function automatic logic [3:0] addr_decode(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] r;
    r = 4'h0;
    case ({hi, lo})
      {PIN_L, PIN_L}:   r = 4'h0;
      {PIN_L, PIN_NC}:  r = 4'h1;
      {PIN_H, PIN_NC}:  r = 4'h2;
      {PIN_L, PIN_H}:   r = 4'h3;
      {PIN_NC, PIN_L}:  r = 4'h4;
      {PIN_NC, PIN_NC}: r = 4'h5;
      {PIN_H, PIN_H}:   r = 4'h6;
      {PIN_NC, PIN_H}:  r = 4'h7;
      {PIN_H, PIN_L}:   r = 4'h8;
      default:          r = 4'h5;
    endcase
    return r;
  endfunction
endpackage

// ### hw/line_sync_if.sv
// synchronised bus lines and straps passed from the synchroniser to the core
`timescale 1ns/10ps
interface line_sync_if;
  logic       scl_s;
  logic       sda_s;
  logic       iso_sda_s;
  logic [1:0] lo_s;
  logic [1:0] hi_s;
  modport src (output scl_s, sda_s, iso_sda_s, lo_s, hi_s);
  modport dst (input scl_s, sda_s, iso_sda_s, lo_s, hi_s);
endinterface

// ### hw/line_sync.sv
// two-flop synchroniser for the bus pins and address straps
`timescale 1ns/10ps
module line_sync
  import iso_i2c_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // raw pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       iso_data_in,
  input wire logic [1:0] pin_lo,
  input wire logic [1:0] pin_hi,
  // synchronised copies
  line_sync_if.src       ls
);
  logic [7:0] meta_reg;
  logic [7:0] sync_reg;

  // lines reset high so no start is seen on release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= SYNC_INIT;
      sync_reg <= SYNC_INIT;
    end else begin
      meta_reg <= {1'b0, pin_hi, pin_lo, iso_data_in, sda_in, scl_in};
      sync_reg <= meta_reg;
    end
  end

  assign ls.scl_s     = sync_reg[0];
  assign ls.sda_s     = sync_reg[1];
  assign ls.iso_sda_s = sync_reg[2];
  assign ls.lo_s      = sync_reg[4:3];
  assign ls.hi_s      = sync_reg[6:5];
endmodule

// ### hw/stuck_timer.sv
// stuck-bus timer on the isolated clock and data lines
`timescale 1ns/10ps
module stuck_timer
  import iso_i2c_pkg::*;
#(
  parameter int LIMIT = STUCK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // line levels
  input wire logic clk_low,
  input wire logic data_low,
  // one-cycle expiry
  output logic     expire
);
  localparam int CW = $clog2(LIMIT + 1);

  generate
    if (LIMIT < 2) begin : g_bad_limit
      $error("stuck_timer LIMIT must be at least 2");
    end
  endgenerate

  logic [CW-1:0] cnt_reg;
  wire           any_low = clk_low | data_low;

  // alternating lows accumulate; only both high clears, saturates at limit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      expire  <= 1'b0;
    end else begin
      if (!any_low) cnt_reg <= '0;
      else if (cnt_reg != CW'(LIMIT)) cnt_reg <= cnt_reg + 1'b1;
      expire <= any_low & (cnt_reg == CW'(LIMIT - 1));
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  timer_clear_a: assert property (!any_low |=> cnt_reg == '0)
    else $error("stuck timer not cleared with both lines high");
  timer_fire_a: assert property (any_low && cnt_reg == CW'(LIMIT - 1) |=> expire)
    else $error("stuck timer did not expire at limit");
  timer_hold_a: assert property (any_low && cnt_reg != CW'(LIMIT) |=> cnt_reg != '0)
    else $error("stuck timer lost accumulated low time");
endmodule

// ### hw/iso_i2c_slave.sv
// isolated serial slave port: clock repeater, data bridge, slave and stuck-bus reset
// Overview of operation
// - clock is repeated logic-to-isolated only; data is bridged both ways
// - result registers and four switch registers are reachable through the pointer
// - slave supports read byte, write byte, read word and write word
// - second byte of a read word repeats the same register
// - stuck timer counts while either isolated line is low, clears when both high
// - a low longer than 66 ms resets the slave state machine
// - alternating lows accumulate toward the same 66 ms limit
// - two three-state straps select one of eight addresses 0010xxx
// - strap lo low, hi high selects broadcast and disables the slave
// - writes to global address 0011111 are accepted unless broadcast mode is selected
// - while alerting, address 0001100 is answered with the alert response
// - the transmitter releases data during the acknowledge pulse
// - as receiver the slave holds data low for the whole acknowledge pulse
// - the command byte low nibble loads the register pointer
// - the data byte after the command is acked and stored; stop ends it
// - a second written data byte is acked and discarded
// - the pointer survives the end of a transaction
// - lowest address wins the alert response; the winner releases its alert
`timescale 1ns/10ps
module iso_i2c_slave
  import iso_i2c_pkg::*;
#(
  parameter int STUCK_LIMIT = STUCK_CYCLES
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              nrst,
  // logic-side bus from the master
  input wire logic              scl_in,
  input wire logic              sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // isolated-side bus
  output logic                  iso_side_clock_out,
  input wire logic              iso_side_data_io_in,
  output logic                  iso_side_data_io_out,
  output logic                  iso_side_data_io_oe,
  // three-state address straps
  input wire logic [1:0]        addr_select_pin_lo,
  input wire logic [1:0]        addr_select_pin_hi,
  // register access
  output logic [PTR_W-1:0]      reg_ptr,
  input wire logic [7:0]        reg_rd_data,
  output logic                  reg_wr_strobe,
  output logic [7:0]            reg_wr_data,
  // alert and mode
  input wire logic              alert_active,
  output logic                  alert_release,
  output logic                  bcast_mode
);
  // the stuck timer needs room to count before it fires
  generate
    if (STUCK_LIMIT < 2) begin : g_bad_stuck
      $error("iso_i2c_slave STUCK_LIMIT must be at least 2");
    end
  endgenerate

  line_sync_if ls ();

  logic stuck_exp;

  line_sync u_sync (
    .clock       (clock),
    .nrst        (nrst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .iso_data_in (iso_side_data_io_in),
    .pin_lo      (addr_select_pin_lo),
    .pin_hi      (addr_select_pin_hi),
    .ls          (ls)
  );

  // isolated clock is our own push-pull output, so its level is known exactly
  stuck_timer #(.LIMIT(STUCK_LIMIT)) u_stuck (
    .clock    (clock),
    .nrst     (nrst),
    .clk_low  (~iso_side_clock_out),
    .data_low (~ls.iso_sda_s),
    .expire   (stuck_exp)
  );

  slave_state_t  state_reg;
  data_owner_t   owner_reg;
  logic          scl_d;
  logic          sda_d;
  logic [3:0]    bit_reg;
  logic [1:0]    byte_reg;
  logic [7:0]    shift_reg;
  logic          rd_mode_reg;
  logic          ara_reg;
  logic          slave_low_reg;
  logic          slave_low_d;
  logic [2:0]    hold_reg;

  // bus events from synchronised lines
  wire scl_rise = ls.scl_s & ~scl_d;
  wire scl_fall = ~ls.scl_s & scl_d;
  wire start_ev = scl_d & ls.scl_s & sda_d & ~ls.sda_s;
  wire stop_ev  = scl_d & ls.scl_s & ~sda_d & ls.sda_s;
  wire byte_end = scl_fall & (bit_reg == 4'h8);

  // address decode from the straps
  wire [3:0] strap_dec = addr_decode(ls.hi_s, ls.lo_s);
  wire       bcast     = strap_dec[3];
  wire [6:0] own_addr  = {ADDR_MSB, 1'b0, strap_dec[2:0]};

  // address match terms, evaluated on the completed address byte
  wire own_hit  = ~bcast & (shift_reg[7:1] == own_addr);
  wire mass_hit = ~bcast & (shift_reg[7:1] == MASS_WR_ADDR) & ~shift_reg[0];
  wire ara_hit  = ~bcast & (shift_reg[7:1] == ALERT_RSP_ADDR) & shift_reg[0] & alert_active;
  wire addr_ack = own_hit | mass_hit | ara_hit;

  // byte to transmit: own address during alert response, else the pointed register
  wire [7:0] tx_byte = ara_reg ? {own_addr, 1'b0} : reg_rd_data;
  wire [3:0] cmd_nib = shift_reg[3:0];

  // arbitration loss: we released a one but the wire reads zero
  wire ara_lost = ara_reg & ~slave_low_reg & ~ls.sda_s;

  // bridge direction: whoever first pulls a side low owns it until it lets go
  wire logic_low = ~ls.sda_s;
  wire iso_low   = ~ls.iso_sda_s;
  wire can_grab  = (owner_reg == OWN_NONE) & (hold_reg == 3'h0) & ~slave_low_reg;
  wire grab_log  = can_grab & logic_low;
  wire grab_iso  = can_grab & ~logic_low & iso_low;
  wire drop_own  = ((owner_reg == OWN_LOGIC) & ~logic_low) |
                   ((owner_reg == OWN_ISO) & ~iso_low);
  wire slave_rel = slave_low_d & ~slave_low_reg;

  // edge detect registers and clock repeater
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_d              <= 1'b1;
      sda_d              <= 1'b1;
      iso_side_clock_out <= 1'b1;
      bcast_mode         <= 1'b0;
    end else begin
      scl_d              <= ls.scl_s;
      sda_d              <= ls.sda_s;
      iso_side_clock_out <= ls.scl_s;
      bcast_mode         <= bcast;
    end
  end

  // data bridge ownership with a holdoff so our own release is not re-captured
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      owner_reg   <= OWN_NONE;
      hold_reg    <= 3'h0;
      slave_low_d <= 1'b0;
    end else begin
      slave_low_d <= slave_low_reg;
      if (drop_own) owner_reg <= OWN_NONE;
      else if (grab_log) owner_reg <= OWN_LOGIC;
      else if (grab_iso) owner_reg <= OWN_ISO;
      if (drop_own | slave_rel) hold_reg <= HOLDOFF;
      else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
  end

  // open-drain enables; the slave drives both sides so either master sees it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_oe              <= 1'b0;
      iso_side_data_io_oe <= 1'b0;
    end else begin
      sda_oe              <= (owner_reg == OWN_ISO) | slave_low_reg;
      iso_side_data_io_oe <= (owner_reg == OWN_LOGIC) | slave_low_reg;
    end
  end

  assign sda_out              = 1'b0;
  assign iso_side_data_io_out = 1'b0;

  // slave state machine; the stuck timer and broadcast mode override everything
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      bit_reg       <= 4'h0;
      byte_reg      <= 2'h0;
      shift_reg     <= 8'h00;
      rd_mode_reg   <= 1'b0;
      ara_reg       <= 1'b0;
      slave_low_reg <= 1'b0;
      reg_ptr       <= '0;
      reg_wr_strobe <= 1'b0;
      reg_wr_data   <= 8'h00;
      alert_release <= 1'b0;
    end else begin
      reg_wr_strobe <= 1'b0;
      alert_release <= 1'b0;
      if (stuck_exp | bcast) begin
        state_reg     <= ST_IDLE;
        slave_low_reg <= 1'b0;
      end else if (start_ev) begin
        state_reg     <= ST_RX;
        bit_reg       <= 4'h0;
        byte_reg      <= 2'h0;
        ara_reg       <= 1'b0;
        slave_low_reg <= 1'b0;
      end else if (stop_ev) begin
        state_reg     <= ST_IDLE;
        slave_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], ls.sda_s};
              bit_reg   <= bit_reg + 4'h1;
            end else if (byte_end) begin
              if (byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
              state_reg     <= ST_RX_ACK;
              slave_low_reg <= 1'b1;
              case (byte_reg)
                2'h0: begin
                  rd_mode_reg <= shift_reg[0];
                  ara_reg     <= ara_hit;
                  alert_release <= own_hit & alert_active;
                  if (!addr_ack) begin
                    state_reg     <= ST_IGNORE;
                    slave_low_reg <= 1'b0;
                  end
                end
                2'h1: reg_ptr <= cmd_nib;
                2'h2: begin
                  reg_wr_strobe <= 1'b1;
                  reg_wr_data   <= shift_reg;
                end
                default: ;
              endcase
            end
          end
          ST_RX_ACK: begin
            if (scl_fall) begin
              bit_reg <= 4'h0;
              if (rd_mode_reg) begin
                state_reg     <= ST_TX;
                shift_reg     <= tx_byte;
                slave_low_reg <= ~tx_byte[7];
              end else begin
                state_reg     <= ST_RX;
                slave_low_reg <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_reg <= bit_reg + 4'h1;
              if (ara_lost) state_reg <= ST_IGNORE;
            end else if (byte_end) begin
              state_reg     <= ST_TX_ACK;
              slave_low_reg <= 1'b0;
              alert_release <= ara_reg;
            end else if (scl_fall) begin
              shift_reg     <= {shift_reg[6:0], 1'b0};
              slave_low_reg <= ~shift_reg[6];
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              if (ls.sda_s) state_reg <= ST_IGNORE;
              else bit_reg <= 4'h9;
            end else if (scl_fall && bit_reg == 4'h9) begin
              state_reg     <= ST_TX;
              bit_reg       <= 4'h0;
              shift_reg     <= tx_byte;
              slave_low_reg <= ~tx_byte[7];
            end
          end
          ST_IGNORE: slave_low_reg <= 1'b0;
          ST_IDLE:   slave_low_reg <= 1'b0;
          default: begin
            state_reg     <= ST_IDLE;
            slave_low_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_rx_end;
    (state_reg == ST_RX) && byte_end && !stuck_exp && !bcast && !start_ev && !stop_ev;
  endsequence
  sequence s_addr_byte;
    s_rx_end ##0 (byte_reg == 2'h0);
  endsequence
  sequence s_cmd_byte;
    s_rx_end ##0 (byte_reg == 2'h1);
  endsequence
  sequence s_data_byte;
    s_rx_end ##0 (byte_reg == 2'h2);
  endsequence
  // transmit steps share the same override guards as the receive path
  sequence s_tx_end;
    (state_reg == ST_TX) && byte_end && !stuck_exp && !bcast && !start_ev && !stop_ev;
  endsequence
  sequence s_tx_next;
    (state_reg == ST_TX_ACK) && scl_fall && (bit_reg == 4'h9) && !stuck_exp && !bcast &&
    !start_ev && !stop_ev;
  endsequence

  clk_repeat_a: assert property ($rose(ls.scl_s) |=> iso_side_clock_out)
    else $error("isolated clock did not follow logic clock");
  stuck_reset_a: assert property (stuck_exp |=> state_reg == ST_IDLE && !slave_low_reg)
    else $error("stuck expiry did not reset the slave");
  bcast_quiet_a: assert property (bcast |=> !slave_low_reg ##1 !slave_low_reg)
    else $error("slave drove data in broadcast mode");
  ack_hold_a: assert property (state_reg == ST_RX_ACK && scl_rise |-> sda_oe && iso_side_data_io_oe)
    else $error("acknowledge not held low");
  tx_release_a: assert property (state_reg == ST_TX_ACK |-> !slave_low_reg)
    else $error("slave drove data in master acknowledge slot");
  ptr_load_a: assert property (s_cmd_byte |=> reg_ptr == $past(cmd_nib))
    else $error("pointer not loaded from command byte");
  wr_store_a: assert property (s_data_byte |=> reg_wr_strobe && reg_wr_data == $past(shift_reg))
    else $error("data byte not stored");
  word_drop_a: assert property (s_rx_end ##0 byte_reg == 2'h3 |=> !reg_wr_strobe)
    else $error("second data byte was written");
  ptr_keep_a: assert property (stop_ev |=> $stable(reg_ptr) [*2])
    else $error("pointer changed at end of transaction");
  no_match_a: assert property (s_addr_byte ##0 !addr_ack |=> state_reg == ST_IGNORE && !slave_low_reg)
    else $error("unmatched address acknowledged");
  mass_ack_a: assert property (s_addr_byte ##0 mass_hit |=> slave_low_reg)
    else $error("global write address not acknowledged");
  // alert response and word read steps
  ara_start_a: assert property (s_addr_byte ##0 ara_hit |=> ara_reg && slave_low_reg)
    else $error("alert response address not acknowledged");
  ara_release_a: assert property (s_tx_end ##0 ara_reg |=> alert_release)
    else $error("alert not released after alert response");
  word_repeat_a: assert property (s_tx_next |=> shift_reg == $past(tx_byte))
    else $error("second read byte not reloaded from the register");
  // a low driven by the master must reach the isolated side
  bridge_fwd_a: assert property (owner_reg == OWN_LOGIC |=> iso_side_data_io_oe)
    else $error("logic side low not forwarded to isolated side");
endmodule

// ### verification/bus_master_model.sv
// bus master model: logic-side clock and open-drain data, stepped on the system clock
`timescale 1ns/10ps
module bus_master_model (
  // system clock
  input wire logic clock,
  // resolved bus levels
  input wire logic sda_wire,
  input wire logic iso_clk,
  // master drives
  output logic     scl,
  output logic     sda_low,
  output logic     iso_seen
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    iso_seen = 1'b0;
  end

  // hold both lines for n cycles; clock and data change on the same edge
  task automatic level(input logic c, input logic d, input int n);
    @(posedge clock);
    scl <= c;
    sda_low <= ~d;
    repeat (n - 1) @(posedge clock);
  endtask

  // one bit at 160 ns: 4 cycles low, 4 high, sampled just before the fall
  task automatic bit_io(input logic b, output logic r);
    @(posedge clock) scl <= 1'b0;
    @(posedge clock) sda_low <= ~b;
    repeat (2) @(posedge clock);
    @(posedge clock) scl <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock) r = sda_wire;
    iso_seen = iso_clk;
  endtask

  // start and repeated start: data falls while the clock is high
  task automatic start();
    level(1'b0, ~sda_low, 2);
    level(1'b0, 1'b1, 2);
    level(1'b1, 1'b1, 4);
    level(1'b1, 1'b0, 4);
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    level(1'b0, ~sda_low, 2);
    level(1'b0, 1'b0, 2);
    level(1'b1, 1'b0, 4);
    level(1'b1, 1'b1, 4);
  endtask

  // send a byte msb first; ack bit released so the slave can answer
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // receive a byte; ack to continue, nack on the last one
  task automatic byte_rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ### verification/isolated_i2c_slave_port_test.sv
// self-checking bench for the isolated serial slave port
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module isolated_i2c_slave_port_test
  import iso_i2c_pkg::*;
;
  logic             clock;
  logic             nrst;
  logic             tgt_low;
  logic             alert_active;
  logic [1:0]       pin_lo;
  logic [1:0]       pin_hi;
  logic [7:0]       regs [16];
  wire logic        scl;
  wire logic        m_low;
  wire logic        sda_out;
  wire logic        sda_oe;
  wire logic        iso_clk;
  wire logic        iso_out;
  wire logic        iso_oe;
  wire logic [3:0]  reg_ptr;
  wire logic        reg_wr_strobe;
  wire logic [7:0]  reg_wr_data;
  wire logic        alert_release;
  wire logic        bcast_mode;
  wire logic        iso_seen;
  int               n_errors = 0;
  int               tests_run = 0;
  int               n_wr = 0;
  int               n_rel = 0;
  int               cycles = 0;
  logic [7:0]       wd;
  // strap table per address index
  logic [1:0]       hi_tab [8] = '{PIN_L, PIN_L, PIN_H, PIN_L, PIN_NC, PIN_NC, PIN_H, PIN_NC};
  logic [1:0]       lo_tab [8] = '{PIN_L, PIN_NC, PIN_NC, PIN_H, PIN_L, PIN_NC, PIN_H, PIN_H};

  // both data wires have pull-ups, so a released line reads high
  wire logic sda_wire = (sda_oe ? sda_out : 1'b1) & ~m_low;
  wire logic iso_wire = (iso_oe ? iso_out : 1'b1) & ~tgt_low;
  wire logic [7:0] rd_data = regs[reg_ptr];

  always #10 clock = ~clock;

  iso_i2c_slave #(.STUCK_LIMIT(200)) dut (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe(sda_oe), .iso_side_clock_out(iso_clk), .iso_side_data_io_in(iso_wire),
    .iso_side_data_io_out(iso_out), .iso_side_data_io_oe(iso_oe),
    .addr_select_pin_lo(pin_lo), .addr_select_pin_hi(pin_hi), .reg_ptr(reg_ptr),
    .reg_rd_data(rd_data), .reg_wr_strobe(reg_wr_strobe), .reg_wr_data(reg_wr_data),
    .alert_active(alert_active), .alert_release(alert_release), .bcast_mode(bcast_mode)
  );

  bus_master_model m (
    .clock(clock), .sda_wire(sda_wire), .iso_clk(iso_clk),
    .scl(scl), .sda_low(m_low), .iso_seen(iso_seen)
  );

  // register file behind the port; counts strobes and alert drops
  always @(posedge clock) begin
    if (reg_wr_strobe === 1'b1) begin
      regs[reg_ptr] <= reg_wr_data;
      wd <= reg_wr_data;
      n_wr <= n_wr + 1;
    end
    if (alert_release === 1'b1) n_rel <= n_rel + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // write: address, command, data, optional ignored second byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic word, output logic [3:0] k);
    k = 4'h0;
    m.start();
    m.byte_wr({a, 1'b0}, k[0]);
    m.byte_wr(c, k[1]);
    m.byte_wr(d, k[2]);
    if (word) m.byte_wr(~d, k[3]);
    m.stop();
  endtask

  // read: optional command phase and repeated start, one or two bytes
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic cmd, input logic word,
                    output logic [1:0] k, output logic [7:0] d0, output logic [7:0] d1);
    logic ka;
    k = 2'h0;
    d1 = 8'h00;
    m.start();
    if (cmd) begin
      m.byte_wr({a, 1'b0}, k[0]);
      m.byte_wr(c, ka);
      k[0] = k[0] & ka;
      m.start();
    end
    m.byte_wr({a, 1'b1}, k[1]);
    m.byte_rd(word, d0);
    if (word) m.byte_rd(1'b0, d1);
    m.stop();
  endtask

  initial begin
    logic [6:0] own;
    logic [7:0] c, d, c2, d0, d1;
    logic [3:0] k;
    logic [1:0] kr;
    int         n0;
    clock = 1'b0;
    nrst = 1'b0;
    tgt_low = 1'b0;
    alert_active = 1'b0;
    pin_lo = PIN_L;
    pin_hi = PIN_L;
    void'($urandom(58));
    foreach (regs[i]) regs[i] = 8'($urandom);
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    // each of the eight address strap settings: write, read back, receive byte, foreign address
    for (int i = 0; i < 8; i++) begin
      pin_hi <= hi_tab[i];
      pin_lo <= lo_tab[i];
      repeat (6) @(posedge clock);
      own = {ADDR_MSB, 4'(i)};
      c = 8'($urandom);
      d = 8'($urandom);
      c2 = 8'($urandom);
      n0 = n_wr;
      wr(own, c, d, i[0], k);
      `CHK("write acks", {i[0], 3'h7}, k)
      `CHK("strobes", n0 + 1, n_wr)
      `CHK("write data", d, wd)
      `CHK("pointer", c[3:0], reg_ptr)
      `CHK("clock repeat", 1'b1, iso_seen)
      rd(own, c2, 1'b1, i[0], kr, d0, d1);
      `CHK("read acks", 2'h3, kr)
      `CHK("read data", regs[c2[3:0]], d0)
      if (i[0]) `CHK("word repeat", d0, d1)
      rd(own, 8'h00, 1'b0, 1'b0, kr, d1, d0);
      `CHK("receive byte", regs[c2[3:0]], d1)
      wr(own ^ 7'h01, c, d, 1'b0, k);
      `CHK("foreign nack", 4'h0, k)
    end
    // mass write reaches the device under the last strap setting of the loop (index 7, not broadcast)
    n0 = n_wr;
    wr(MASS_WR_ADDR, c, d, 1'b0, k);
    `CHK("mass acks", 4'h7, k)
    `CHK("mass strobe", n0 + 1, n_wr)
    // alert response address only answered while alerting
    rd(ALERT_RSP_ADDR, 8'h00, 1'b0, 1'b0, kr, d0, d1);
    `CHK("alert idle nack", 1'b0, kr[1])
    alert_active <= 1'b1;
    n0 = n_rel;
    rd(ALERT_RSP_ADDR, 8'h00, 1'b0, 1'b0, kr, d0, d1);
    alert_active <= 1'b0;
    `CHK("alert ack", 1'b1, kr[1])
    `CHK("alert address", {own, 1'b0}, d0)
    `CHK("alert drop", n0 + 1, n_rel)
    // broadcast strap disables the slave
    pin_hi <= PIN_H;
    pin_lo <= PIN_L;
    repeat (6) @(posedge clock);
    `CHK("broadcast", 1'b1, bcast_mode)
    wr(own, c, d, 1'b0, k);
    `CHK("broadcast nack", 4'h0, k)
    pin_hi <= hi_tab[7];
    pin_lo <= lo_tab[7];
    repeat (6) @(posedge clock);
    `CHK("slave back", 1'b0, bcast_mode)
    // short clock hold survives, a long one resets the slave
    n0 = n_wr;
    m.start();
    m.byte_wr({own, 1'b0}, k[0]);
    m.level(1'b0, 1'b1, 120);
    `CHK("clock low", 1'b0, iso_clk)
    m.byte_wr(c | 8'h80, k[1]);
    `CHK("short hold", 2'h3, k[1:0])
    m.level(1'b0, 1'b1, 220);
    m.byte_wr(d, k[2]);
    `CHK("stuck clock", 1'b0, k[2])
    m.stop();
    // alternating lows with no both-high moment add up past the limit
    m.start();
    m.byte_wr({own, 1'b0}, k[0]);
    m.level(1'b0, 1'b1, 80);
    tgt_low <= 1'b1;
    m.level(1'b0, 1'b1, 20);
    m.level(1'b1, 1'b1, 60);
    m.level(1'b0, 1'b1, 20);
    tgt_low <= 1'b0;
    m.level(1'b0, 1'b1, 60);
    m.byte_wr(d, k[1]);
    `CHK("alternating", 2'h1, k[1:0])
    `CHK("no stuck write", n0, n_wr)
    m.stop();
    close_out();
  end
endmodule
